//--- rtl/oc_pkg.sv
/*
 * Constants and carrier types for the enable-source, clear-faults and
 * write-guard command block.
 * Assumes a PMBus front end on the same clock that decodes each
 * transaction into one command request.
 */
package oc_pkg;

    // ========================================================
    // Command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ONOFF     = 8'h02;
    localparam logic [7:0] CMD_CLEAR     = 8'h03;
    localparam logic [7:0] CMD_GUARD     = 8'h10;
    localparam logic [7:0] CMD_STORE     = 8'h11;
    localparam logic [7:0] CMD_RESTORE   = 8'h12;
    localparam logic [7:0] CMD_VOUT      = 8'h21;
    localparam logic [7:0] CMD_VENDOR_F0 = 8'hf0;

    // ========================================================
    // Field positions and reset values
    localparam int         ONOFF_CPA     = 0;
    localparam int         ONOFF_POL     = 1;
    localparam int         ONOFF_CPR     = 2;
    localparam int         ONOFF_CMD     = 3;
    localparam int         ONOFF_PU      = 4;
    localparam int         ONOFF_W       = 5;
    localparam logic [4:0] ONOFF_RESET   = 5'h16;
    localparam int         GUARD_LSB     = 5;
    localparam int         GUARD_W       = 3;
    localparam logic [2:0] GUARD_RESET   = 3'h0;
    localparam logic [2:0] GUARD_SELF    = 3'h4;
    localparam logic [2:0] GUARD_OP      = 3'h2;
    localparam logic [2:0] GUARD_CFG     = 3'h1;
    localparam int         F0_OV_REL     = 0;
    localparam logic [7:0] F0_RESET      = 8'h00;

    // ========================================================
    // Timing
    localparam int PIN_LOW_NS    = 100;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PIN_LOW_CYC   =
        (PIN_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PIN_CNT_W     = 6;

    // ========================================================
    // Types
    typedef struct packed {
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } oc_cmd_req_t;

    typedef struct packed {
        logic       ack;
        logic       nack;
        logic [7:0] rdata;
    } oc_cmd_rsp_t;

    typedef struct packed {
        logic [7:0] onoff;
        logic [7:0] guard;
        logic [7:0] vendor;
    } oc_nv_image_t;

    typedef enum logic [1:0] {
        OC_IDLE = 2'b00,
        OC_RUN  = 2'b01,
        OC_SOFT = 2'b10
    } oc_conv_state_t;

endpackage : oc_pkg

//--- rtl/oc_ctrl.sv
/*
 * Enable-source configuration, clear-faults and write-guard logic.
 * Assumes same-clock command requests, OPERATION bits, fault levels and
 * a nonvolatile image; the on/off pin, power-good and feedback compare
 * arrive asynchronously.
 */
module oc_ctrl #(
    parameter int N_FAULT = 8
) (
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire logic                 cmd_valid,
    input  wire oc_pkg::oc_cmd_req_t  cmd_req,
    output logic                      rsp_valid,
    output oc_pkg::oc_cmd_rsp_t       rsp,
    output logic                      write_permit,
    input  wire logic                 loop_slave,
    input  wire logic                 on_off_pin,
    input  wire logic                 input_power_ok,
    input  wire logic                 feedback_below_ref,
    input  wire logic                 op_on,
    input  wire logic                 op_soft,
    input  wire logic [N_FAULT-1:0]   fault_cond,
    input  wire logic                 fault_latch_off,
    input  wire logic                 ov_latch_fault,
    input  wire logic                 ramp_done,
    input  wire oc_pkg::oc_nv_image_t nv_image,
    output logic                      nv_store,
    output oc_pkg::oc_nv_image_t      nv_store_image,
    output logic                      status_clear,
    output logic [N_FAULT-1:0]        status_out,
    output logic                      cml_fault,
    output logic                      invalid_command_fault,
    output logic                      alert_line,
    output logic                      conv_enable,
    output logic                      soft_stop,
    output logic                      hard_stop,
    output logic                      low_side_switch
);

    // ========================================================
    // Guard decode
    function automatic logic guard_allows(input logic [2:0] lvl,
                                          input logic [7:0] code);
        logic ok;
        ok = 1'b1;
        case (lvl)
            oc_pkg::GUARD_SELF: ok = (code == oc_pkg::CMD_GUARD);
            oc_pkg::GUARD_OP:   ok = (code == oc_pkg::CMD_GUARD) ||
                                     (code == oc_pkg::CMD_OPERATION);
            oc_pkg::GUARD_CFG:  ok = (code == oc_pkg::CMD_GUARD) ||
                                     (code == oc_pkg::CMD_OPERATION) ||
                                     (code == oc_pkg::CMD_ONOFF) ||
                                     (code == oc_pkg::CMD_VOUT);
            default:            ok = 1'b1;
        endcase
        return ok;
    endfunction : guard_allows

    // ========================================================
    // Synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {feedback_below_ref, input_power_ok, on_off_pin};
            sync2_reg <= sync1_reg;
        end
    end

    logic pin_s;
    logic power_s;
    logic fb_low_s;
    assign pin_s    = sync2_reg[0];
    assign power_s  = sync2_reg[1];
    assign fb_low_s = sync2_reg[2];

    // ========================================================
    // Command decode
    logic [4:0]         onoff_reg;
    logic [2:0]         guard_reg;
    logic [7:0]         vendor_reg;
    logic               pol_use_reg;
    logic               pol_loaded_reg;
    logic [2:0]         guard_eff;
    logic               is_onoff;
    logic               slave_block;
    logic               wr_ok;
    logic               do_clear_cmd;
    logic               do_restore;
    logic               guard_bad_wr;

    assign guard_eff    = $onehot(guard_reg) ? guard_reg : 3'h0;
    assign is_onoff     = (cmd_req.code == oc_pkg::CMD_ONOFF);
    assign slave_block  = cmd_valid && is_onoff && loop_slave;
    assign write_permit = guard_allows(guard_eff, cmd_req.code);
    assign wr_ok        = cmd_valid && cmd_req.write && write_permit &&
                          !slave_block;
    assign do_clear_cmd = cmd_valid && (cmd_req.code == oc_pkg::CMD_CLEAR);
    assign do_restore   = cmd_valid && (cmd_req.code == oc_pkg::CMD_RESTORE);
    assign guard_bad_wr = wr_ok && (cmd_req.code == oc_pkg::CMD_GUARD) &&
                          !$onehot0(cmd_req.data[7:5]);

    // ========================================================
    // Configuration registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            onoff_reg <= oc_pkg::ONOFF_RESET;
        end else if (wr_ok && is_onoff) begin
            onoff_reg <= cmd_req.data[4:0];
        end else if (do_restore &&
                     guard_allows(guard_eff, oc_pkg::CMD_ONOFF)) begin
            onoff_reg <= nv_image.onoff[4:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            guard_reg <= oc_pkg::GUARD_RESET;
        end else if (wr_ok && cmd_req.code == oc_pkg::CMD_GUARD) begin
            guard_reg <= cmd_req.data[7:5];
        end else if (do_restore) begin
            guard_reg <= nv_image.guard[7:5];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            vendor_reg <= oc_pkg::F0_RESET;
        end else if (wr_ok && cmd_req.code == oc_pkg::CMD_VENDOR_F0) begin
            vendor_reg <= cmd_req.data;
        end else if (do_restore &&
                     guard_allows(guard_eff, oc_pkg::CMD_VENDOR_F0)) begin
            vendor_reg <= nv_image.vendor;
        end
    end

    // Polarity in use is taken from the stored image once after reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pol_use_reg    <= oc_pkg::ONOFF_RESET[oc_pkg::ONOFF_POL];
            pol_loaded_reg <= 1'b0;
        end else if (!pol_loaded_reg) begin
            pol_use_reg    <= nv_image.onoff[oc_pkg::ONOFF_POL];
            pol_loaded_reg <= 1'b1;
        end
    end

    // ========================================================
    // Store and response
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            nv_store       <= 1'b0;
            nv_store_image <= '0;
        end else begin
            nv_store <= cmd_valid && cmd_req.code == oc_pkg::CMD_STORE;
            if (cmd_valid && cmd_req.code == oc_pkg::CMD_STORE) begin
                nv_store_image <= {3'h0, onoff_reg, guard_reg, 5'h00,
                                   vendor_reg};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
        end else begin
            rsp_valid <= cmd_valid;
            rsp.ack   <= cmd_valid && !slave_block;
            rsp.nack  <= slave_block;
            case (cmd_req.code)
                oc_pkg::CMD_ONOFF:
                    rsp.rdata <= slave_block ? 8'h00 : {3'h0, onoff_reg};
                oc_pkg::CMD_GUARD:     rsp.rdata <= {guard_reg, 5'h00};
                oc_pkg::CMD_VENDOR_F0: rsp.rdata <= vendor_reg;
                default:               rsp.rdata <= 8'h00;
            endcase
        end
    end

    // ========================================================
    // Pin toggle clear
    logic [oc_pkg::PIN_CNT_W-1:0] low_cnt_reg;
    logic                         pin_prev_reg;
    logic                         pin_clear;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_reg  <= '0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_s;
            if (pin_s) begin
                low_cnt_reg <= '0;
            end else if (low_cnt_reg <= oc_pkg::PIN_CNT_W'(oc_pkg::PIN_LOW_CYC))
            begin
                low_cnt_reg <= low_cnt_reg + 1'b1;
            end
        end
    end

    assign pin_clear = pin_s && !pin_prev_reg &&
        (low_cnt_reg > oc_pkg::PIN_CNT_W'(oc_pkg::PIN_LOW_CYC));

    // ========================================================
    // Status and alert
    logic               clear_all;
    logic [N_FAULT-1:0] status_next;
    logic               cml_next;
    logic               ivc_next;

    assign clear_all   = do_clear_cmd || pin_clear;
    assign status_next = (clear_all ? '0 : status_out) | fault_cond;
    assign cml_next    = (clear_all ? 1'b0 : cml_fault) | guard_bad_wr;
    assign ivc_next    = (clear_all ? 1'b0 : invalid_command_fault) |
                         slave_block;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            status_out            <= '0;
            cml_fault             <= 1'b0;
            invalid_command_fault <= 1'b0;
            alert_line            <= 1'b0;
            status_clear          <= 1'b0;
        end else begin
            status_out            <= status_next;
            cml_fault             <= cml_next;
            invalid_command_fault <= ivc_next;
            alert_line            <= |{status_next, cml_next, ivc_next};
            status_clear          <= clear_all;
        end
    end

    // ========================================================
    // Latch-off and low-side hold
    logic latched_reg;
    logic enable_req;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latched_reg <= 1'b0;
        end else if (fault_latch_off || ov_latch_fault) begin
            latched_reg <= 1'b1;
        end else if (!enable_req) begin
            latched_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            low_side_switch <= 1'b0;
        end else if (ov_latch_fault) begin
            low_side_switch <= 1'b1;
        end else if (vendor_reg[oc_pkg::F0_OV_REL] ? fb_low_s : clear_all)
        begin
            low_side_switch <= 1'b0;
        end
    end

    // ========================================================
    // Enable decision and turn-off sequence
    logic                   pin_act;
    logic                   pin_ok;
    logic                   op_ok;
    logic                   run_ok;
    oc_pkg::oc_conv_state_t state_reg;

    assign pin_act = pol_use_reg ? pin_s : !pin_s;
    assign pin_ok  = !onoff_reg[oc_pkg::ONOFF_CPR] || pin_act;
    assign op_ok   = !onoff_reg[oc_pkg::ONOFF_CMD] || op_on;
    assign enable_req = !onoff_reg[oc_pkg::ONOFF_PU] ||
                        (pin_ok && op_ok);
    assign run_ok  = power_s && enable_req && !latched_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= oc_pkg::OC_IDLE;
            hard_stop <= 1'b0;
        end else begin
            hard_stop <= 1'b0;
            case (state_reg)
                oc_pkg::OC_IDLE: begin
                    if (run_ok) begin
                        state_reg <= oc_pkg::OC_RUN;
                    end
                end
                oc_pkg::OC_RUN: begin
                    if (!run_ok) begin
                        if (!power_s || latched_reg) begin
                            state_reg <= oc_pkg::OC_IDLE;
                            hard_stop <= 1'b1;
                        end else if (!pin_ok) begin
                            state_reg <= onoff_reg[oc_pkg::ONOFF_CPA] ?
                                oc_pkg::OC_IDLE : oc_pkg::OC_SOFT;
                            hard_stop <= onoff_reg[oc_pkg::ONOFF_CPA];
                        end else begin
                            state_reg <= op_soft ?
                                oc_pkg::OC_SOFT : oc_pkg::OC_IDLE;
                            hard_stop <= !op_soft;
                        end
                    end
                end
                oc_pkg::OC_SOFT: begin
                    if (!power_s || latched_reg) begin
                        state_reg <= oc_pkg::OC_IDLE;
                        hard_stop <= 1'b1;
                    end else if (ramp_done) begin
                        state_reg <= oc_pkg::OC_IDLE;
                    end
                end
                default: state_reg <= oc_pkg::OC_IDLE;
            endcase
        end
    end

    assign conv_enable = (state_reg == oc_pkg::OC_RUN);
    assign soft_stop   = (state_reg == oc_pkg::OC_SOFT);

    // ========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    slave_nack_a: assert property (slave_block |=> rsp.nack &&
        invalid_command_fault && alert_line)
        else $error("loop-slave access not refused");
    slave_keep_a: assert property (slave_block && cmd_req.write |=>
        $stable(onoff_reg))
        else $error("loop-slave write changed config");
    pu_off_run_a: assert property (state_reg == oc_pkg::OC_IDLE &&
        power_s && !onoff_reg[oc_pkg::ONOFF_PU] && !latched_reg |=>
        conv_enable)
        else $error("conversion not started with gating off");
    cmd_gate_a: assert property (conv_enable && onoff_reg[oc_pkg::ONOFF_PU]
        && onoff_reg[oc_pkg::ONOFF_CMD] && !op_on |=> !conv_enable)
        else $error("on bit ignored while obeyed");
    pol_fixed_a: assert property (pol_loaded_reg |=> $stable(pol_use_reg))
        else $error("polarity in use changed");
    pin_hard_a: assert property (conv_enable && power_s && !latched_reg &&
        onoff_reg[oc_pkg::ONOFF_PU] && !pin_ok &&
        onoff_reg[oc_pkg::ONOFF_CPA] |=> hard_stop && !soft_stop)
        else $error("pin off not immediate");
    clear_all_a: assert property (do_clear_cmd && fault_cond == '0 |=>
        status_out == '0 && !cml_fault)
        else $error("clear-faults left status set");
    refault_a: assert property (do_clear_cmd && fault_cond[0] |=>
        status_out[0] && alert_line)
        else $error("present fault not set again");
    latch_hold_a: assert property (fault_latch_off |=> latched_reg ##1
        !conv_enable)
        else $error("latched unit still runs");
    ls_hold_a: assert property (low_side_switch &&
        !vendor_reg[oc_pkg::F0_OV_REL] && !clear_all && !ov_latch_fault
        |=> low_side_switch)
        else $error("low-side switch released early");
    guard_self_a: assert property (guard_eff == oc_pkg::GUARD_SELF &&
        cmd_valid && cmd_req.write && is_onoff |=> $stable(onoff_reg))
        else $error("protected write accepted");
    guard_bad_a: assert property (guard_bad_wr |=> cml_fault && alert_line
        && guard_eff == 3'h0)
        else $error("invalid guard value not flagged");

    soft_seen_c: cover property (conv_enable ##1 soft_stop [*2]
        ##1 !soft_stop);
    pin_clear_c: cover property (pin_clear);
    restore_c:   cover property (do_restore && guard_eff != 3'h0);

endmodule : oc_ctrl

//--- verif/oc_host.sv
/*
 * Host-side model: issues one decoded command per call, captures the answer.
 * Assumes the block takes cmd_valid on a rising clock edge and registers
 * its answer on that same edge.
 */
module oc_host #(
    parameter int CLR_WAIT = 16
) (
    input  wire logic                clock,
    output logic                     cmd_valid,
    output oc_pkg::oc_cmd_req_t      cmd_req,
    input  wire logic                rsp_valid,
    input  wire oc_pkg::oc_cmd_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 100ps;
    oc_pkg::oc_cmd_rsp_t last_rsp;
    logic                got_rsp;
    initial begin
        cmd_valid = 1'b0;
        cmd_req   = '0;
    end
    // ==========================================================
    // One command, answer taken at the edge after the request
    task automatic issue(input logic wr, input logic [7:0] code,
                         input logic [7:0] data);
        @(posedge clock);
        #1;
        cmd_valid = 1'b1;
        cmd_req   = '{write: wr, code: code, data: data};
        @(posedge clock);
        #1;
        got_rsp   = rsp_valid;
        last_rsp  = rsp;
        cmd_valid = 1'b0;
        cmd_req   = ~cmd_req;
    endtask : issue
    // ==========================================================
    // Clear faults after the settle wait
    task automatic clear_faults();
        repeat (CLR_WAIT) @(posedge clock);
        issue(1'b0, oc_pkg::CMD_CLEAR, 8'h00);
    endtask : clear_faults
endmodule : oc_host

//--- verif/testbench.sv
/*
 * Self-checking bench: register, guard, clear, enable and store tests.
 * Assumes oc_ctrl with its package; the host model drives the command port.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst_b, cmd_valid, rsp_valid, write_permit, loop_slave;
    logic on_off_pin, input_power_ok, feedback_below_ref, op_on, op_soft;
    logic fault_latch_off, ov_latch_fault, ramp_done, nv_store;
    logic status_clear, cml_fault, invalid_command_fault, alert_line;
    logic conv_enable, soft_stop, hard_stop, low_side_switch;
    logic [7:0]           fault_cond, status_out, cfg;
    oc_pkg::oc_cmd_req_t  cmd_req;
    oc_pkg::oc_cmd_rsp_t  rsp;
    oc_pkg::oc_nv_image_t nv_image, nv_store_image;
    int                   fail_count, n_checks, cycles;
    logic [7:0]           gv [4] = '{8'h80, 8'h40, 8'h20, 8'h60};
    logic [3:0]           gok = 4'b1100;
    logic                 permit_seen;
    int                   n_hard;

    oc_ctrl #(.N_FAULT(8)) dut (
        .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_req(cmd_req), .rsp_valid(rsp_valid), .rsp(rsp),
        .write_permit(write_permit), .loop_slave(loop_slave),
        .on_off_pin(on_off_pin),
        .input_power_ok(input_power_ok), .op_on(op_on), .op_soft(op_soft),
        .feedback_below_ref(feedback_below_ref), .fault_cond(fault_cond),
        .fault_latch_off(fault_latch_off), .ov_latch_fault(ov_latch_fault),
        .ramp_done(ramp_done), .nv_image(nv_image), .nv_store(nv_store),
        .nv_store_image(nv_store_image), .status_clear(status_clear),
        .status_out(status_out), .cml_fault(cml_fault),
        .invalid_command_fault(invalid_command_fault),
        .alert_line(alert_line), .conv_enable(conv_enable),
        .soft_stop(soft_stop), .hard_stop(hard_stop),
        .low_side_switch(low_side_switch));
    oc_host host (.clock(clock), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
        .rsp_valid(rsp_valid), .rsp(rsp));

    initial clock = 1'b0;
    always #2 clock = ~clock;
    // Permission seen with each request, count of hard stops
    always @(posedge clock) begin
        if (cmd_valid) permit_seen <= write_permit;
        if (hard_stop) n_hard <= n_hard + 1;
    end
    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wt
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        host.issue(1'b0, c, 8'h00);
        check({host.got_rsp, host.last_rsp.rdata}, {1'b1, e});
    endtask : rd
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        host.issue(1'b1, c, d);
        check({host.got_rsp, host.last_rsp.ack}, 2'b11);
    endtask : wr
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end
    // ==========================================================
    // Tests
    initial begin
        {rst_b, loop_slave, on_off_pin, input_power_ok, op_on, op_soft} = '0;
        {feedback_below_ref, fault_latch_off, ov_latch_fault, ramp_done} = '0;
        fault_cond = 8'h00;
        nv_image   = '{onoff: 8'h16, guard: 8'h00, vendor: 8'h00};
        wt(16);
        rst_b = 1'b1;
        rd(oc_pkg::CMD_ONOFF, 8'h16);
        rd(oc_pkg::CMD_GUARD, 8'h00);
        wr(oc_pkg::CMD_ONOFF, 8'hff);
        rd(oc_pkg::CMD_ONOFF, 8'h1f);
        $display("end register test");
        cfg = 8'h1f;
        for (int i = 0; i < 4; i++) begin
            wr(oc_pkg::CMD_GUARD, gv[i]);
            rd(oc_pkg::CMD_GUARD, gv[i]);
            wr(oc_pkg::CMD_ONOFF, 8'h0a + 8'(i));
            check(permit_seen, gok[i]);
            if (gok[i]) cfg = 8'h0a + 8'(i);
            rd(oc_pkg::CMD_ONOFF, cfg);
        end
        check({cml_fault, alert_line}, 2'b11);
        wr(oc_pkg::CMD_GUARD, 8'h00);
        host.clear_faults();
        check({cml_fault, alert_line, status_clear}, 3'b001);
        $display("end guard test");
        fault_cond = 8'h04;
        wt(2);
        host.clear_faults();
        check({status_out, alert_line}, {8'h04, 1'b1});
        fault_cond = 8'h00;
        host.clear_faults();
        check({status_out, alert_line}, 9'h000);
        loop_slave = 1'b1;
        host.issue(1'b1, oc_pkg::CMD_ONOFF, 8'h00);
        check({host.last_rsp.ack, host.last_rsp.nack}, 2'b01);
        wt(1);
        check({invalid_command_fault, alert_line}, 2'b11);
        loop_slave = 1'b0;
        rd(oc_pkg::CMD_ONOFF, cfg);
        host.clear_faults();
        $display("end fault test");
        input_power_ok = 1'b1;
        wr(oc_pkg::CMD_ONOFF, 8'h00);
        wt(8);
        check(conv_enable, 1'b1);
        wr(oc_pkg::CMD_ONOFF, 8'h18);
        wt(8);
        check(conv_enable, 1'b0);
        op_on = 1'b1;
        wt(8);
        check(conv_enable, 1'b1);
        {op_on, op_soft} = 2'b01;
        wt(4);
        check({conv_enable, soft_stop}, 2'b01);
        {op_on, ramp_done} = 2'b11;
        wt(8);
        {op_soft, ramp_done} = 2'b00;
        check(conv_enable, 1'b1);
        wr(oc_pkg::CMD_ONOFF, 8'h1c);
        wt(8);
        check(conv_enable, 1'b0);
        ramp_done = 1'b1;
        wt(1);
        ramp_done = 1'b0;
        on_off_pin = 1'b1;
        wt(8);
        check(conv_enable, 1'b1);
        fault_cond = 8'h01;
        wt(1);
        fault_cond = 8'h00;
        on_off_pin = 1'b0;
        wt(6);
        check({conv_enable, soft_stop}, 2'b01);
        ramp_done = 1'b1;
        wt(28);
        ramp_done = 1'b0;
        on_off_pin = 1'b1;
        wt(8);
        check({status_out, conv_enable}, 9'h001);
        wr(oc_pkg::CMD_ONOFF, 8'h1d);
        on_off_pin = 1'b0;
        wt(6);
        check({conv_enable, soft_stop}, 2'b00);
        check(n_hard, 2);
        on_off_pin = 1'b1;
        wt(8);
        ov_latch_fault = 1'b1;
        wt(1);
        ov_latch_fault = 1'b0;
        wt(3);
        check({low_side_switch, conv_enable}, 2'b10);
        host.clear_faults();
        wt(3);
        check({low_side_switch, conv_enable}, 2'b00);
        $display("end enable test");
        wr(oc_pkg::CMD_GUARD, 8'h20);
        host.issue(1'b0, oc_pkg::CMD_STORE, 8'h00);
        check({nv_store, nv_store_image}, {1'b1, 24'h1d2000});
        wr(oc_pkg::CMD_GUARD, 8'h80);
        nv_image = '{onoff: 8'h16, guard: 8'h80, vendor: 8'h00};
        host.issue(1'b0, oc_pkg::CMD_RESTORE, 8'h00);
        rd(oc_pkg::CMD_ONOFF, 8'h1d);
        rd(oc_pkg::CMD_GUARD, 8'h80);
        $display("end store test");
        test_done();
    end
endmodule : testbench
